// ---- hdl/phfd_cfg.svh ----
`ifndef PHFD_CFG_SVH
`define PHFD_CFG_SVH

// Sample width in bits
`define PHFD_DW 16
// Coefficient width in bits
`define PHFD_CW 16
// Largest tap count held in the coefficient store and delay line
`define PHFD_NT 32
// Largest decimation or interpolation factor
`define PHFD_RMAX 8
// Output buffer depth in words
`define PHFD_FDEPTH 16
// Fixed rate of both half-band structures
`define PHFD_HB_RATE 2
// Half-band tap count must leave this remainder modulo four
`define PHFD_HB_LEN_MOD 2'h3

`endif

// ---- hdl/phfd_coef_mem.sv ----
`timescale 1ns/1ps
`default_nettype none

// Coefficient store: one write port, two registered read ports
module phfd_coef_mem #(
	parameter int CW    = 16,
	parameter int DEPTH = 32,
	parameter int AW    = 5
) (
	input  wire logic          sys_clk,
	input  wire logic          resetn,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [CW-1:0] wdata,
	input  wire logic [AW-1:0] raddr_a,
	input  wire logic [AW-1:0] raddr_b,
	output logic      [CW-1:0] rdata_a,
	output logic      [CW-1:0] rdata_b
);
	logic [CW-1:0] mem_q [DEPTH];	// No reset: contents must be loaded

	// Write port
	always_ff @(posedge sys_clk) begin
		if (we) begin
			mem_q[waddr] <= wdata;
		end
	end

	// Registered reads, one cycle after the address
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rdata_a <= '0;
			rdata_b <= '0;
		end else begin
			rdata_a <= mem_q[raddr_a];
			rdata_b <= mem_q[raddr_b];
		end
	end
endmodule

`default_nettype wire

// ---- hdl/phfd_datapath.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "phfd_cfg.svh"

module phfd_datapath #(
	parameter int DW     = `PHFD_DW,
	parameter int CW     = `PHFD_CW,
	parameter int NT     = `PHFD_NT,
	parameter int RMAX   = `PHFD_RMAX,
	parameter int FDEPTH = `PHFD_FDEPTH,
	parameter int AW     = $clog2(NT),
	parameter int TW     = $clog2(NT + 1),
	parameter int RW     = $clog2(RMAX + 1),
	parameter int OW     = DW + CW + TW + 1
) (
	input  wire logic                 sys_clk,
	input  wire logic                 resetn,
	input  wire phfd_pkg::phfd_mode_e cfg_mode,
	input  wire logic [RW-1:0]        cfg_rate,
	input  wire logic [TW-1:0]        cfg_ntaps,
	input  wire logic                 cfg_sym_en,
	output logic                      cfg_hb_len_err,
	input  wire logic                 coef_we,
	input  wire logic [AW-1:0]        coef_addr,
	input  wire logic [CW-1:0]        coef_wdata,
	input  wire logic                 s_valid,
	output logic                      s_ready,
	input  wire logic [DW-1:0]        s_data,
	output logic                      m_valid,
	input  wire logic                 m_ready,
	output logic      [OW-1:0]        m_data
);
	import phfd_pkg::*;

	localparam int IW = TW + RW + 1;			// Raw coefficient index width
	localparam int HW = (RMAX / 2 > 1) ? RMAX / 2 : 1;	// Stash entries
	localparam int SW = (HW > 1) ? $clog2(HW) : 1;		// Stash index width

	// Picks a coefficient behind the front padding; flags out-of-range taps
	function automatic logic [TW:0] coef_pick(input logic [IW-1:0] raw,
		input logic [RW-1:0] pad_v, input logic [TW-1:0] n);
		logic [IW-1:0] eff;
		logic          ok;
		eff = raw - IW'(pad_v);
		ok  = (raw >= IW'(pad_v)) && (eff < IW'(n));
		return {ok, eff[TW-1:0]};
	endfunction

	phfd_state_e          state_q;		// Sequencer state
	phfd_state_e          state_d;		// Next state
	logic signed [DW-1:0] xd_q [NT];	// Sample delay line, newest at 0
	logic [RW-1:0]        comm_q;		// Inputs delivered this commutator turn
	logic [RW-1:0]        phase_q;		// Interpolator output phase
	logic [TW-1:0]        step_q;		// Multiply index within one output
	logic signed [OW-1:0] acc_s_q;		// Sum accumulator
	logic signed [OW-1:0] acc_d_q;		// Difference accumulator
	logic signed [OW-1:0] stash_q [HW];	// Upper phase results of pairs
	logic                 p_vld_q;		// Product stage holds a step
	logic                 p_va_q;		// Coefficient A is a real tap
	logic                 p_vb_q;		// Coefficient B is a real tap
	logic signed [DW-1:0] p_x_q;		// Sample for the product stage
	logic [CW-1:0]        rd_a;		// Coefficient A from the store
	logic [CW-1:0]        rd_b;		// Coefficient B from the store

	phfd_stream_if #(.W(OW)) emit_if ();	// Results towards the buffer

	// Mode decode
	wire is_dec  = cfg_mode == PHFD_DEC;
	wire is_int  = cfg_mode == PHFD_INT;
	wire is_hbd  = cfg_mode == PHFD_HBD;
	wire is_hbi  = cfg_mode == PHFD_HBI;
	wire is_hb   = is_hbd | is_hbi;
	wire dec_any = is_dec | is_hbd;
	wire int_any = is_int | is_hbi;

	// Half-band structures run at a fixed factor of two
	wire [RW-1:0] eff_rate = is_hb ? RW'(`PHFD_HB_RATE) : cfg_rate;
	// Guards the divider against a zero rate
	wire [RW-1:0] rate_g   = (cfg_rate == '0) ? RW'(1) : cfg_rate;

	// Only 3+4n taps put the structural zeros inside the response
	assign cfg_hb_len_err = is_hb & (cfg_ntaps[1:0] != `PHFD_HB_LEN_MOD);

	// Tap geometry
	wire [TW:0]   n_p1   = {1'b0, cfg_ntaps} + {{TW{1'b0}}, 1'b1};
	wire [TW-1:0] half_n = n_p1[TW:1];		// Even-indexed taps
	wire [TW-1:0] centre = cfg_ntaps >> 1;		// Centre tap index
	wire [TW-1:0] hbi_di = centre >> 1;		// Sample meeting the centre tap

	// Rate two with odd taps already gives symmetric phases
	wire sym_act = cfg_sym_en & is_int & (cfg_rate >= RW'(2))
		& ~((cfg_rate == RW'(2)) & cfg_ntaps[0]);
	wire [RW-1:0] mirror    = eff_rate - phase_q - 1'b1;
	wire          pair_act  = sym_act & (phase_q < mirror);
	wire          stash_hit = sym_act & (phase_q > mirror);

	// Front padding aligns a partial subfilter for pairing
	wire [RW-1:0] n_mod = RW'(cfg_ntaps % rate_g);
	wire [RW-1:0] pad   = (sym_act && n_mod != '0) ? RW'(rate_g - n_mod) : '0;
	wire [TW+1:0] int_sum   = (TW + 2)'(cfg_ntaps) + (TW + 2)'(pad) + (TW + 2)'(rate_g)
		- (TW + 2)'(1);
	wire [TW-1:0] int_steps = TW'(int_sum / (TW + 2)'(rate_g));

	// Multiplies per output for each structure
	wire [TW-1:0] nsteps = is_dec ? cfg_ntaps :
		is_hbd ? TW'(half_n + 1'b1) :
		is_int ? int_steps :
		(phase_q == '0) ? half_n : TW'(1);

	// Per-step tap and sample selection
	wire [IW-1:0] step_w = IW'(step_q);
	wire [IW-1:0] step2  = IW'({step_q, 1'b0});
	wire          hb_arm = step_q < half_n;
	wire [IW-1:0] int_ra = IW'(phase_q) + IW'(IW'(eff_rate) * step_w);
	wire [IW-1:0] int_rb = IW'(mirror) + IW'(IW'(eff_rate) * step_w);
	// In the half-band modes port A fetches no odd tap other than the centre; port B reads odd taps but its product is masked off
	wire [IW-1:0] raw_a  = is_dec ? step_w :
		is_hbd ? (hb_arm ? step2 : IW'(centre)) :
		is_int ? int_ra :
		(phase_q == '0) ? step2 : IW'(centre);
	wire [TW-1:0] di     = is_dec ? step_q :
		is_hbd ? (hb_arm ? step2[TW-1:0] : centre) :
		is_int ? step_q :
		(phase_q == '0) ? step_q : hbi_di;
	wire [TW:0]   pick_a = coef_pick(raw_a, pad, cfg_ntaps);
	wire [TW:0]   pick_b = coef_pick(int_rb, pad, cfg_ntaps);

	// Handshake and sequencing terms
	wire accept     = s_valid & s_ready;
	wire dec_fire   = dec_any & (comm_q == eff_rate - 1'b1);
	wire start      = accept & (int_any | dec_fire);
	wire issue      = (state_q == ST_MAC) & ~stash_hit;
	wire last_issue = issue & (step_q == nsteps - 1'b1);
	wire emit_go    = (state_q == ST_EMIT) & emit_if.ready;
	wire more_phase = int_any & (phase_q != eff_rate - 1'b1);
	wire acc_clr    = start | (emit_go & more_phase);

	// Product stage: coefficients arrive one cycle after the address
	wire signed [CW-1:0]    ca    = p_va_q ? $signed(rd_a) : '0;
	wire signed [CW-1:0]    cb    = p_vb_q ? $signed(rd_b) : '0;
	wire signed [CW:0]      sum_c = {ca[CW-1], ca} + {cb[CW-1], cb};
	wire signed [CW:0]      dif_c = {cb[CW-1], cb} - {ca[CW-1], ca};
	wire signed [CW+DW:0]   prd_s = sum_c * p_x_q;
	wire signed [CW+DW:0]   prd_d = dif_c * p_x_q;

	// Pair recovery: halved sum and difference of the two subfilters
	wire signed [OW:0]   rec_lo  = {acc_s_q[OW-1], acc_s_q} - {acc_d_q[OW-1], acc_d_q};
	wire signed [OW:0]   rec_hi  = {acc_s_q[OW-1], acc_s_q} + {acc_d_q[OW-1], acc_d_q};
	wire signed [OW-1:0] half_lo = rec_lo[OW:1];
	wire signed [OW-1:0] half_hi = rec_hi[OW:1];

	// Input taken only while the sequencer is idle; a busy filter stalls upstream
	assign s_ready       = state_q == ST_IDLE;
	assign emit_if.valid = state_q == ST_EMIT;
	assign emit_if.data  = stash_hit ? stash_q[mirror[SW-1:0]] :
		pair_act ? half_lo : acc_s_q;

	// Next-state logic
	always_comb begin
		case (state_q)
			ST_IDLE: begin
				state_d = start ? ST_MAC : ST_IDLE;
			end
			ST_MAC: begin
				// Stashed phases need no arithmetic
				if (stash_hit) begin
					state_d = ST_EMIT;
				end else if (last_issue) begin
					state_d = ST_DRAIN;
				end else begin
					state_d = ST_MAC;
				end
			end
			ST_DRAIN: begin
				state_d = ST_EMIT;
			end
			ST_EMIT: begin
				if (!emit_go) begin
					state_d = ST_EMIT;
				end else if (more_phase) begin
					state_d = ST_MAC;
				end else begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Delay line shared by all phases and segments
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			for (int k = 0; k < NT; k++) begin
				xd_q[k] <= '0;
			end
		end else if (accept) begin
			xd_q[0] <= s_data;
			for (int k = 1; k < NT; k++) begin
				xd_q[k] <= xd_q[k-1];
			end
		end
	end

	// Commutator: segment index is rate-1-comm_q, so it walks M-1 down to 0
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			comm_q <= '0;
		end else if (accept && dec_any) begin
			comm_q <= dec_fire ? '0 : comm_q + 1'b1;
		end
	end

	// Phase and step counters
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			phase_q <= '0;
			step_q  <= '0;
		end else begin
			if (start) begin
				phase_q <= '0;
			end else if (emit_go && more_phase) begin
				phase_q <= phase_q + 1'b1;
			end
			if (acc_clr || last_issue) begin
				step_q <= '0;
			end else if (issue) begin
				step_q <= step_q + 1'b1;
			end
		end
	end

	// Product stage registers; padded or absent taps count as zero
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			p_vld_q <= 1'b0;
			p_va_q  <= 1'b0;
			p_vb_q  <= 1'b0;
			p_x_q   <= '0;
		end else begin
			p_vld_q <= issue;
			p_va_q  <= issue & pick_a[TW];
			p_vb_q  <= issue & pair_act & pick_b[TW];
			p_x_q   <= xd_q[di[AW-1:0]];
		end
	end

	// Accumulators: cleared at the start of each output
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			acc_s_q <= '0;
			acc_d_q <= '0;
		end else if (acc_clr) begin
			acc_s_q <= '0;
			acc_d_q <= '0;
		end else if (p_vld_q) begin
			acc_s_q <= acc_s_q + OW'(prd_s);
			acc_d_q <= acc_d_q + OW'(prd_d);
		end
	end

	// Upper result of each pair waits for its own phase
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			for (int k = 0; k < HW; k++) begin
				stash_q[k] <= '0;
			end
		end else if (emit_go && pair_act) begin
			stash_q[phase_q[SW-1:0]] <= half_hi;
		end
	end

	// Coefficient store; the loader writes every tap, zeros included
	phfd_coef_mem #(
		.CW    (CW),
		.DEPTH (NT),
		.AW    (AW)
	) u_coef (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.we      (coef_we),
		.waddr   (coef_addr),
		.wdata   (coef_wdata),
		.raddr_a (pick_a[AW-1:0]),
		.raddr_b (pick_b[AW-1:0]),
		.rdata_a (rd_a),
		.rdata_b (rd_b)
	);

	// Output buffer; its full flag holds the sequencer in emit
	phfd_fifo #(
		.W     (OW),
		.DEPTH (FDEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.resetn    (resetn),
		.in_if     (emit_if),
		.out_valid (m_valid),
		.out_ready (m_ready),
		.out_data  (m_data)
	);
endmodule

`default_nettype wire

// ---- hdl/phfd_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none

// Output buffer; depth must be a power of two
module phfd_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16
) (
	input  wire logic         sys_clk,
	input  wire logic         resetn,
	phfd_stream_if.snk        in_if,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	logic [W-1:0] mem_q [DEPTH];	// Storage flops
	logic [PW:0]  wr_q;		// Write pointer with wrap bit
	logic [PW:0]  rd_q;		// Read pointer with wrap bit
	wire          full  = (wr_q ^ rd_q) == {1'b1, {PW{1'b0}}};
	wire          empty = wr_q == rd_q;
	wire          push  = in_if.valid & ~full;
	wire          pop   = out_ready & ~empty;

	// Full stalls the sequencer, never drops a word
	assign in_if.ready = ~full;
	assign out_valid   = ~empty;
	assign out_data    = mem_q[rd_q[PW-1:0]];

	// Storage write
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_q[wr_q[PW-1:0]] <= in_if.data;
		end
	end

	// Pointer update
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end
endmodule

`default_nettype wire

// ---- hdl/phfd_pkg.sv ----
package phfd_pkg;

	// Filter structure selected on the configuration inputs
	typedef enum logic [1:0] {
		PHFD_DEC = 2'h0,	// Polyphase decimator, M-to-1
		PHFD_INT = 2'h1,	// Polyphase interpolator, 1-to-P
		PHFD_HBD = 2'h2,	// Half-band decimator
		PHFD_HBI = 2'h3		// Half-band interpolator
	} phfd_mode_e;

	// Sequencer states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,	// Waiting for an input sample
		ST_MAC   = 4'h2,	// Issuing one multiply per cycle
		ST_DRAIN = 4'h4,	// Last product still in the pipe
		ST_EMIT  = 4'h8		// Result offered to the output buffer
	} phfd_state_e;

endpackage

// ---- hdl/phfd_stream_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// Valid/ready word stream between the sequencer and the buffer
interface phfd_stream_if #(
	parameter int W = 8
) ();
	logic         valid;	// Word on data is offered
	logic         ready;	// Sink can take the word
	logic [W-1:0] data;	// Payload

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// ---- testbench/phfd_peer.sv ----
`timescale 1ns/1ps
`default_nettype none

// Upstream source and downstream sink around the datapath
module phfd_peer #(
	parameter int DW = 16,
	parameter int OW = 39
) (
	input  wire logic          sys_clk,
	input  wire logic          s_ready,
	output logic               s_valid,
	output logic      [DW-1:0] s_data,
	input  wire logic          m_valid,
	output logic               m_ready,
	input  wire logic [OW-1:0] m_data
);
	logic [DW-1:0] src_q[$];	// Samples still to offer
	logic [OW-1:0] got_q[$];	// Results taken
	int            stall_pct = 0;	// Chance of refusing a result

	initial begin
		s_valid = 1'b0;
		s_data  = '0;
		m_ready = 1'b0;
	end

	// Handshakes sampled at the edge, lines moved just after it
	always @(posedge sys_clk) begin
		if (m_valid && m_ready)
			got_q.push_back(m_data);
		if (s_valid && s_ready)
			void'(src_q.pop_front());
		#1;
		// Offer held until taken; idle line inverts its bits every cycle
		s_valid <= src_q.size() > 0;
		s_data  <= (src_q.size() > 0) ? src_q[0] : ~s_data;
		m_ready <= ($urandom % 100) >= stall_pct;
	end
endmodule

`default_nettype wire

// ---- testbench/phfd_props.sv ----
`timescale 1ns/1ps
`default_nettype none

// Port-level checks on the filter datapath
module phfd_props #(
	parameter int RW = 4,
	parameter int TW = 6,
	parameter int OW = 39
) (
	input wire logic                 sys_clk,
	input wire logic                 resetn,
	input wire phfd_pkg::phfd_mode_e cfg_mode,
	input wire logic [RW-1:0]        cfg_rate,
	input wire logic [TW-1:0]        cfg_ntaps,
	input wire logic                 cfg_hb_len_err,
	input wire logic                 s_valid,
	input wire logic                 s_ready,
	input wire logic                 m_valid,
	input wire logic                 m_ready,
	input wire logic [OW-1:0]        m_data
);
	import phfd_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	logic in_x;	// Sample taken
	logic out_x;	// Result taken
	logic dec_m;	// A decimating structure
	logic last;	// Sample closes a group
	logic stall_q;	// Sink has refused once
	logic span_ok;	// Busy span fits the multiply count
	int   grp_q;	// Position in the group
	int   low_q;	// Cycles with input refused
	int   in_q;	// Samples taken
	int   out_q;	// Results taken
	int   m_w;	// Effective rate
	int   need;	// Busy cycles per result

	assign in_x  = s_valid & s_ready;
	assign out_x = m_valid & m_ready;
	assign dec_m = cfg_mode inside {PHFD_DEC, PHFD_HBD};
	assign m_w   = cfg_mode[1] ? 2 : int'(cfg_rate);
	assign last  = grp_q == m_w - 1;
	// Busy span only exact while the buffer never fills
	assign need  = (cfg_mode == PHFD_DEC) ? int'(cfg_ntaps) + 2 : (int'(cfg_ntaps) + 1) / 2 + 3;
	// Exact span until the sink has refused a result once
	assign span_ok = stall_q ? low_q >= need : low_q == need;

	// Group, busy and traffic counters
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			grp_q   <= 0;
			low_q   <= 0;
			in_q    <= 0;
			out_q   <= 0;
			stall_q <= 1'b0;
		end else begin
			if (in_x && dec_m)
				grp_q <= last ? 0 : grp_q + 1;
			low_q <= s_ready ? 0 : low_q + 1;
			in_q  <= in_q + int'(in_x);
			out_q <= out_q + int'(out_x);
			if (m_valid && !m_ready)
				stall_q <= 1'b1;
		end
	end

	sequence grp_end_s;
		in_x && dec_m && last;
	endsequence
	sequence grp_mid_s;
		in_x && dec_m && !last;
	endsequence

	hb_len_a: assert property (cfg_hb_len_err == (cfg_mode[1] && cfg_ntaps[1:0] != 2'h3))
		else $error("half-band length flag wrong");
	out_hold_a: assert property (m_valid && !m_ready |=> m_valid && $stable(m_data))
		else $error("result dropped or changed while refused");
	grp_busy_a: assert property (grp_end_s |=> !s_ready)
		else $error("no computation after a full group");
	grp_mid_a: assert property (grp_mid_s |=> s_ready)
		else $error("group samples not taken back to back");
	mac_len_a: assert property ($rose(s_ready) && dec_m |-> span_ok)
		else $error("wrong number of multiply cycles");
	rate_a: assert property (dec_m ? out_q * m_w <= in_q : out_q <= in_q * m_w)
		else $error("more results than the rate allows");
	int_busy_a: assert property (in_x && !dec_m |=> !s_ready [*3])
		else $error("interpolator took a sample while busy");
	rst_out_a: assert property ($rose(resetn) |-> !m_valid && s_ready)
		else $error("state after reset wrong");
endmodule

`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "phfd_cfg.svh"

module tb;
	import phfd_pkg::*;
	localparam int OW = `PHFD_DW + `PHFD_CW + $clog2(`PHFD_NT + 1) + 1;	// Result width

	logic          sys_clk    = 1'b0;
	logic          resetn     = 1'b0;
	phfd_mode_e    cfg_mode   = PHFD_DEC;
	logic [3:0]    cfg_rate   = 4'h1;
	logic [5:0]    cfg_ntaps  = 6'h01;
	logic          cfg_sym_en = 1'b0;
	logic          coef_we    = 1'b0;
	logic [4:0]    coef_addr  = 5'h00;
	logic [15:0]   coef_wdata = 16'h0000;
	logic          cfg_hb_len_err;
	logic          s_valid;
	logic          s_ready;
	logic [15:0]   s_data;
	logic          m_valid;
	logic          m_ready;
	logic [OW-1:0] m_data;
	int            fail_count = 0;	// Mismatches
	int            compares   = 0;	// Comparisons made
	int            a[32];	// Coefficients loaded
	int            x[$];	// Samples sent

	// 40 MHz clock
	always #12.5 sys_clk = ~sys_clk;

	phfd_datapath dut (.sys_clk(sys_clk), .resetn(resetn), .cfg_mode(cfg_mode),
		.cfg_rate(cfg_rate), .cfg_ntaps(cfg_ntaps), .cfg_sym_en(cfg_sym_en),
		.cfg_hb_len_err(cfg_hb_len_err), .coef_we(coef_we), .coef_addr(coef_addr),
		.coef_wdata(coef_wdata), .s_valid(s_valid), .s_ready(s_ready), .s_data(s_data),
		.m_valid(m_valid), .m_ready(m_ready), .m_data(m_data));

	phfd_peer #(.DW(16), .OW(OW)) peer (.sys_clk(sys_clk), .s_ready(s_ready),
		.s_valid(s_valid), .s_data(s_data), .m_valid(m_valid), .m_ready(m_ready),
		.m_data(m_data));

	// Compare and count
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic test_done;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Inputs move just after the edge
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask

	// One configuration: load, stream, compare with reference sums
	task automatic run(input phfd_mode_e md, input int r, input int n, input bit sym,
			input int nin, input int stall);
		int  m;
		int  pad;
		int  ne;
		int  idx;
		longint y;
		resetn = 1'b0;
		cfg_mode = md;
		cfg_rate = 4'(r);
		cfg_ntaps = 6'(n);
		cfg_sym_en = sym;
		peer.stall_pct = stall;
		tick(2);
		resetn = 1'b1;
		// Symmetric set; half-band odd taps zero bar the centre
		for (int k = 0; k < n; k++) begin
			a[k] = (k >= (n + 1) / 2) ? a[n-1-k] : int'($urandom % 4096) - 2048;
			if (md[1] && k % 2 == 1 && 2 * k != n - 1)
				a[k] = 0;
			coef_we = 1'b1;
			coef_addr = 5'(k);
			coef_wdata = 16'(a[k]);
			tick(1);
		end
		coef_we = 1'b0;
		m = md[1] ? 2 : r;
		pad = (md == PHFD_INT && sym && r >= 2 && !(r == 2 && n % 2)) ? (r - n % r) % r : 0;
		ne = (md inside {PHFD_DEC, PHFD_HBD}) ? nin / m : nin * m;
		x.delete();
		for (int j = 0; j < nin; j++) begin
			x.push_back(int'($signed(16'($urandom))));
			peer.src_q.push_back(16'(x[j]));
		end
		// Full buffer must hold off new samples
		if (stall == 100) begin
			tick(300);
			chk("s_ready", 0, s_ready);
			peer.stall_pct = 30;
		end
		for (int t = 0; t < 20000 && peer.got_q.size() < ne; t++)
			tick(1);
		chk("count", ne, peer.got_q.size());
		if (peer.got_q.size() < ne)
			test_done();
		for (int j = 0; j < nin; j++) begin
			for (int i = 0; i < m; i++) begin
				y = 0;
				if (md inside {PHFD_DEC, PHFD_HBD}) begin
					if (i > 0 || j % m != m - 1)
						continue;
					for (int k = 0; k < n && k <= j; k++)
						y += longint'(a[k]) * x[j-k];
				end else begin
					for (int q = 0; q <= j; q++) begin
						idx = i + m * q - pad;
						if (idx >= 0 && idx < n)
							y += longint'(a[idx]) * x[j-q];
					end
				end
				chk("m_data", 64'($unsigned(OW'(y))), 64'(peer.got_q.pop_front()));
			end
		end
		tick(5);
		chk("m_valid", 0, m_valid);
		chk("extra", 0, peer.got_q.size());
	endtask

	// Main sequence
	initial begin
		void'($urandom(95));
		tick(6);
		resetn = 1'b1;
		// Length flag over both half-band modes
		for (int n = 3; n < 16; n++) begin
			cfg_mode = phfd_mode_e'(2 + n % 2);
			cfg_ntaps = 6'(n);
			tick(1);
			chk("hb_len_err", n % 4 != 3, cfg_hb_len_err);
		end
		cfg_mode = PHFD_DEC;
		cfg_ntaps = 6'h09;
		tick(1);
		chk("hb_len_err", 0, cfg_hb_len_err);
		run(PHFD_DEC, 3, 8, 0, 12, 0);
		run(PHFD_DEC, 8, 32, 0, 32, 30);
		run(PHFD_INT, 3, 7, 0, 6, 0);
		run(PHFD_INT, 3, 15, 1, 6, 0);
		run(PHFD_INT, 4, 14, 1, 5, 0);
		run(PHFD_INT, 2, 5, 1, 6, 0);
		run(PHFD_HBD, 1, 11, 0, 12, 0);
		run(PHFD_HBI, 1, 7, 0, 6, 20);
		run(PHFD_INT, 8, 8, 0, 4, 100);
		test_done();
	end
endmodule

bind phfd_datapath phfd_props #(.RW(RW), .TW(TW), .OW(OW)) u_props (
	.sys_clk(sys_clk), .resetn(resetn), .cfg_mode(cfg_mode), .cfg_rate(cfg_rate),
	.cfg_ntaps(cfg_ntaps), .cfg_hb_len_err(cfg_hb_len_err), .s_valid(s_valid),
	.s_ready(s_ready), .m_valid(m_valid), .m_ready(m_ready), .m_data(m_data));

`default_nettype wire
